// ### rtl/sss_sequencer.sv
// Start-up sequencer: run line, turn-on delay, digital soft-start ramp, GPIO
//
// The implementer's own choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ns
module sss_sequencer #(
    parameter int unsigned DEGLITCH_CYCLES = sss_pkg::DEGLITCH_CYC
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic init_done,
    input wire logic vin_above_on,
    input wire logic vout_above_uv,
    input wire logic reverse_current,
    input wire logic bottom_gate_req,
    input wire logic run_in,
    output logic run_out,
    output logic run_oe_n,
    input wire logic share_clk_in,
    output logic share_clk_out,
    output logic share_clk_oe_n,
    output logic gpio_out,
    output logic gpio_oe_n,
    output logic [15:0] target_code,
    output logic switching_en,
    output logic force_dcm,
    output logic [1:0] pwm_mode,
    output logic servo_start,
    output logic bottom_gate_en
);
    import sss_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        sss_state_t st;
        logic [2:0] vin_s;
        logic [2:0] run_s;
        logic [2:0] vout_s;
        logic [2:0] rev_s;
        logic [2:0] sh_s;
        logic vin_f;
        logic run_f;
        logic vout_f;
        logic rev_f;
        logic sh_f;
        logic [15:0] shdiv;
        logic shphase;
        logic [15:0] cnt;
        logic [15:0] stepcnt;
        logic [15:0] nsteps;
        logic [15:0] num;
        logic [15:0] den;
        logic [15:0] quo;
        logic [16:0] rem;
        logic [3:0] bitidx;
        logic [15:0] inc;
        logic [15:0] remv;
        logic [16:0] err;
        logic [15:0] target;
        logic [15:0] dgcnt;
        logic uv_dg;
        logic [15:0] setpoint;
        logic [15:0] wait_time;
        logic [15:0] rise_time;
        logic [1:0] propagate;
        logic [1:0] mode;
        logic a_wr;
        logic a_rd;
        logic rd_ok;
        logic [7:0] a_addr;
        logic [31:0] rdata;
    } sss_regs_t;

    sss_regs_t q;
    sss_regs_t d;
    logic tick;
    logic ramp_active;
    logic uv_sel;
    logic [16:0] trial;
    logic [16:0] err_sum;

    // Change counts once second and third stage agree
    function automatic logic filt(input logic [2:0] s, input logic f);
        filt = (s[1] == s[2]) ? s[2] : f;
    endfunction : filt

    function automatic logic [31:0] rd_word(input sss_regs_t r, input logic [7:0] a);
        rd_word = 32'h00000000;
        case (a)
            OFS_SETPOINT: rd_word = {16'h0000, r.setpoint};
            OFS_WAIT: rd_word = {16'h0000, r.wait_time};
            OFS_RISE: rd_word = {16'h0000, r.rise_time};
            OFS_PROPAGATE: rd_word = {30'h00000000, r.propagate};
            OFS_MODE: rd_word = {30'h00000000, r.mode};
            OFS_STATUS: rd_word = {21'h000000, r.st, 3'h0, r.uv_dg, r.vout_f, r.vin_f, r.run_f, r.sh_f};
            OFS_TARGET: rd_word = {16'h0000, r.target};
            default: rd_word = 32'h00000000;
        endcase
    endfunction : rd_word

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        d = q;
        // Pin synchronisers, three stages each
        d.vin_s = {q.vin_s[1:0], vin_above_on};
        d.run_s = {q.run_s[1:0], run_in};
        d.vout_s = {q.vout_s[1:0], vout_above_uv};
        d.rev_s = {q.rev_s[1:0], reverse_current};
        d.sh_s = {q.sh_s[1:0], share_clk_in};
        d.vin_f = filt(q.vin_s, q.vin_f);
        d.run_f = filt(q.run_s, q.run_f);
        d.vout_f = filt(q.vout_s, q.vout_f);
        d.rev_f = filt(q.rev_s, q.rev_f);
        d.sh_f = filt(q.sh_s, q.sh_f);

        // Own share clock; wired low wins, so the slowest peer sets the pace
        if (q.shdiv == 16'(SHARE_HALF_CYC - 1))
        begin
            d.shdiv = 16'h0000;
            d.shphase = ~q.shphase;
        end
        else
        begin
            d.shdiv = q.shdiv + 16'h0001;
        end
        tick = q.sh_f & ~q.sh_s[2] & ~q.sh_s[1] ? 1'b0 : (d.sh_f & ~q.sh_f);

        // Sequential restoring divider, one bit per cycle
        trial = {q.rem[15:0], q.num[q.bitidx]};
        err_sum = q.err + {1'b0, q.remv};

        case (q.st)
            ST_HOLD:
            begin
                if (init_done && q.vin_f)
                begin
                    d.st = ST_ARM;
                end
            end
            ST_ARM:
            begin
                d.target = 16'h0000;
                if (!q.vin_f || !init_done)
                begin
                    d.st = ST_HOLD;
                end
                else if (d.run_f && !q.run_f)
                begin
                    d.cnt = 16'h0000;
                    d.st = ST_DELAY;
                end
            end
            ST_DELAY:
            begin
                if (tick)
                begin
                    if (q.cnt >= q.wait_time)
                    begin
                        d.cnt = 16'h0000;
                        if (q.rise_time < MIN_RISE_TICKS)
                        begin
                            d.target = q.setpoint;
                            d.st = ST_SETTLE;
                        end
                        else
                        begin
                            d.num = q.rise_time;
                            d.den = STEP_TICKS;
                            d.rem = 17'h00000;
                            d.bitidx = 4'hF;
                            d.st = ST_DIV1;
                        end
                    end
                    else
                    begin
                        d.cnt = q.cnt + 16'h0001;
                    end
                end
            end
            ST_DIV1, ST_DIV2:
            begin
                if (trial >= {1'b0, q.den})
                begin
                    d.rem = trial - {1'b0, q.den};
                    d.quo[q.bitidx] = 1'b1;
                end
                else
                begin
                    d.rem = trial;
                    d.quo[q.bitidx] = 1'b0;
                end
                d.bitidx = q.bitidx - 4'h1;
                if (q.bitidx == 4'h0)
                begin
                    d.bitidx = 4'hF;
                    if (q.st == ST_DIV1)
                    begin
                        d.nsteps = d.quo;
                        d.num = q.setpoint;
                        d.den = d.quo;
                        d.rem = 17'h00000;
                        d.st = ST_DIV2;
                    end
                    else
                    begin
                        d.inc = d.quo;
                        d.remv = d.rem[15:0];
                        d.err = 17'h00000;
                        d.stepcnt = 16'h0000;
                        d.target = 16'h0000;
                        d.st = ST_RAMP;
                    end
                end
            end
            ST_RAMP:
            begin
                if (tick)
                begin
                    d.cnt = q.cnt + 16'h0001;
                    if (q.cnt == STEP_TICKS - 16'h0001)
                    begin
                        d.cnt = 16'h0000;
                        d.stepcnt = q.stepcnt + 16'h0001;
                        if (q.stepcnt + 16'h0001 >= q.nsteps)
                        begin
                            d.target = q.setpoint;
                            d.st = ST_SETTLE;
                        end
                        else if (err_sum >= {1'b0, q.nsteps})
                        begin
                            d.err = err_sum - {1'b0, q.nsteps};
                            d.target = q.target + q.inc + 16'h0001;
                        end
                        else
                        begin
                            d.err = err_sum;
                            d.target = q.target + q.inc;
                        end
                    end
                end
            end
            ST_SETTLE:
            begin
                if (q.vout_f)
                begin
                    d.st = ST_ON;
                end
            end
            ST_ON:
            begin
                d.st = ST_ON;
            end
            default:
            begin
                d.st = ST_HOLD;
            end
        endcase
        // Losing the run line abandons the start-up; soft-off is not handled here
        if (q.st != ST_HOLD && q.st != ST_ARM && !q.run_f)
        begin
            d.target = 16'h0000;
            d.st = ST_ARM;
        end

        // Deglitch filter on the undervoltage indication
        if (q.vout_f == q.uv_dg)
        begin
            d.dgcnt = 16'h0000;
        end
        else if (q.dgcnt == 16'(DEGLITCH_CYCLES - 1))
        begin
            d.dgcnt = 16'h0000;
            d.uv_dg = q.vout_f;
        end
        else
        begin
            d.dgcnt = q.dgcnt + 16'h0001;
        end

        // Bus slave: writes land in the first data-phase cycle, reads wait one
        d.rd_ok = 1'b0;
        if (q.a_wr)
        begin
            case (q.a_addr)
                OFS_SETPOINT: d.setpoint = hwdata[15:0];
                OFS_WAIT: d.wait_time = hwdata[15:0];
                OFS_RISE: d.rise_time = hwdata[15:0];
                OFS_PROPAGATE: d.propagate = hwdata[1:0];
                OFS_MODE: d.mode = hwdata[1:0];
                default: d.mode = q.mode;
            endcase
        end
        if (q.a_rd && !q.rd_ok)
        begin
            d.rdata = rd_word(q, q.a_addr);
            d.rd_ok = 1'b1;
        end
        if (hreadyout)
        begin
            d.a_wr = hsel & hready & (htrans == HTRANS_NONSEQ) & hwrite;
            d.a_rd = hsel & hready & (htrans == HTRANS_NONSEQ) & ~hwrite;
            d.a_addr = haddr[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            q <= '0;
            q.st <= ST_HOLD;
            q.setpoint <= SETPOINT_RST;
            q.wait_time <= WAIT_RST;
            q.rise_time <= RISE_RST;
            q.propagate <= PROPAGATE_RST;
            q.mode <= MODE_RST;
        end
        else
        begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign hreadyout = ~(q.a_rd & ~q.rd_ok);
    assign hrdata = q.rdata;
    assign hresp = 1'b0;
    assign run_out = 1'b0;
    assign run_oe_n = (q.st != ST_HOLD);
    assign share_clk_out = 1'b0;
    assign share_clk_oe_n = q.shphase;
    assign ramp_active = (q.st == ST_DIV1) | (q.st == ST_DIV2) | (q.st == ST_RAMP) | (q.st == ST_SETTLE);
    assign force_dcm = ramp_active;
    assign pwm_mode = ramp_active ? MODE_DCM : q.mode;
    assign servo_start = (q.st == ST_ON);
    assign switching_en = ramp_active | servo_start;
    assign target_code = q.target;
    // Pre-biased start: no sinking while discontinuous
    assign bottom_gate_en = bottom_gate_req & switching_en & ~((pwm_mode == MODE_DCM) & q.rev_f);
    assign uv_sel = q.propagate[PROP_DEGLITCH_BIT] ? q.uv_dg : q.vout_f;
    assign gpio_out = 1'b0;
    assign gpio_oe_n = ~(q.propagate[PROP_ENABLE_BIT] & ~uv_sel);
endmodule : sss_sequencer

// ### shared/sss_pkg.sv
// Constants and types of the start-up delay and soft-start sequencer
package sss_pkg;
    localparam int unsigned CLK_NS = 10;
    localparam int unsigned TICK_NS = 10000;
    localparam int unsigned SHARE_HALF_CYC = TICK_NS / CLK_NS / 2;
    localparam int unsigned STEP_NS = 100000;
    localparam logic [15:0] STEP_TICKS = 16'(STEP_NS / TICK_NS);
    localparam int unsigned MIN_RISE_NS = 250000;
    localparam logic [15:0] MIN_RISE_TICKS = 16'(MIN_RISE_NS / TICK_NS);
    localparam int unsigned DEGLITCH_NS = 70000;
    localparam int unsigned DEGLITCH_CYC = DEGLITCH_NS / CLK_NS;
    localparam logic [7:0] OFS_SETPOINT = 8'h00;
    localparam logic [7:0] OFS_WAIT = 8'h04;
    localparam logic [7:0] OFS_RISE = 8'h08;
    localparam logic [7:0] OFS_PROPAGATE = 8'h0C;
    localparam logic [7:0] OFS_MODE = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_TARGET = 8'h18;
    localparam int unsigned PROP_ENABLE_BIT = 0;
    localparam int unsigned PROP_DEGLITCH_BIT = 1;
    localparam logic [15:0] SETPOINT_RST = 16'h0000;
    localparam logic [15:0] WAIT_RST = 16'h0000;
    localparam logic [15:0] RISE_RST = 16'h0000;
    localparam logic [1:0] PROPAGATE_RST = 2'h0;
    localparam logic [1:0] MODE_RST = 2'h0;
    localparam logic [1:0] MODE_DCM = 2'h1;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef enum logic [2:0] {
        ST_HOLD, ST_ARM, ST_DELAY, ST_DIV1, ST_DIV2, ST_RAMP, ST_SETTLE, ST_ON
    } sss_state_t;
endpackage : sss_pkg

// ### test/sss_peer.sv
// Peer controller model sharing the run and shared clock lines
`timescale 1ns/1ns
module sss_peer (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic peer_ready,
    input wire logic clk_hold,
    output logic run_oe_n,
    output logic share_clk_oe_n
);
    ////////////////////////////////////////////////////////////////
    // Peer holds run low until its own start-up is done
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            run_oe_n <= 1'b0;
        else
            run_oe_n <= peer_ready;
    // Holding the wired clock low stalls every sharer's time base
    assign share_clk_oe_n = ~clk_hold;
endmodule : sss_peer

// ### test/sss_sequencer_bench.sv
// Self-checking bench of the start-up sequencer
`timescale 1ns/1ns
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; $display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); end end
`define WAITC(c, l) n = 0; while (!(c) && n < (l)) begin @(negedge hclk); n++; end
module sss_sequencer_bench;
    import sss_pkg::*;
    typedef struct { logic [7:0] a; logic [31:0] w, r0, r1; } sss_row_t;
    logic hclk, hresetn, hsel, hwrite, init_done, vin_above_on, vout_above_uv, hreadyout, hresp;
    logic reverse_current, bottom_gate_req, peer_ready, clk_hold, run_oe_n, share_clk_oe_n, gpio_oe_n;
    logic switching_en, force_dcm, servo_start, bottom_gate_en, peer_run_oe_n, peer_clk_oe_n;
    logic run_in, share_clk_in;
    logic [31:0] haddr, hwdata, hrdata, t;
    logic [1:0] htrans, pwm_mode;
    logic [2:0] hsize;
    logic [15:0] target_code, last;
    int mismatches, checked, n, steps;
    sss_row_t rows [7] = '{
        '{OFS_SETPOINT, 32'hFFFFFFFF, {16'h0000, SETPOINT_RST}, 32'h0000FFFF},
        '{OFS_WAIT, 32'hFFFFFFFF, {16'h0000, WAIT_RST}, 32'h0000FFFF},
        '{OFS_RISE, 32'hFFFFFFFF, {16'h0000, RISE_RST}, 32'h0000FFFF},
        '{OFS_PROPAGATE, 32'hFFFFFFFF, {30'h0, PROPAGATE_RST}, 32'h00000003},
        '{OFS_MODE, 32'hFFFFFFFF, {30'h0, MODE_RST}, 32'h00000003},
        '{OFS_TARGET, 32'hFFFFFFFF, 32'h00000000, 32'h00000000},
        '{8'h20, 32'hFFFFFFFF, 32'h00000000, 32'h00000000}
    };
    ////////////////////////////////////////////////////////////////
    // Pull-up lines: low while any party pulls
    assign run_in = run_oe_n & peer_run_oe_n;
    assign share_clk_in = share_clk_oe_n & peer_clk_oe_n;
    // Short filter keeps the deglitch case brief
    sss_sequencer #(.DEGLITCH_CYCLES(20)) DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .init_done, .vin_above_on, .vout_above_uv,
        .reverse_current, .bottom_gate_req, .run_in, .run_out(), .run_oe_n, .share_clk_in, .share_clk_out(),
        .share_clk_oe_n, .gpio_out(), .gpio_oe_n, .target_code, .switching_en, .force_dcm, .pwm_mode,
        .servo_start, .bottom_gate_en);
    sss_peer u_peer (.hclk, .hresetn, .peer_ready, .clk_hold, .run_oe_n(peer_run_oe_n),
        .share_clk_oe_n(peer_clk_oe_n));
    ////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        if (mismatches == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : wrap_up
    // Ready looked at on the falling edge, so it is settled before the sampling edge
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        do @(negedge hclk); while (hreadyout !== 1'b1);
        @(posedge hclk);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(negedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        @(posedge hclk);
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(a, 1'b1, d, t);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(a, 1'b0, 32'h00000000, t);
        `CHK(t, e)
    endtask : rd
    ////////////////////////////////////////////////////////////////
    initial
    begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    initial
    begin
        #600000;
        mismatches++;
        wrap_up();
    end
    initial
    begin
        {hresetn, hsel, hwrite, init_done, vin_above_on, vout_above_uv} = 6'h00;
        {reverse_current, bottom_gate_req, peer_ready, clk_hold} = 4'h0;
        {haddr, hwdata, htrans} = 66'h0;
        hsize = 3'h2;
        repeat (8) @(posedge hclk);
        `CHK(run_oe_n, 1'b0)
        `CHK(gpio_oe_n, 1'b1)
        hresetn <= 1'b1;
        foreach (rows[i])
        begin
            rd(rows[i].a, rows[i].r0);
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a, rows[i].r1);
        end
        wr(OFS_SETPOINT, 32'h00000064);
        wr(OFS_WAIT, 32'h00000002);
        wr(OFS_RISE, 32'h0000001E);
        wr(OFS_PROPAGATE, 32'h00000001);
        wr(OFS_MODE, 32'h00000002);
        vin_above_on <= 1'b1;
        repeat (20) @(negedge hclk);
        `CHK(run_oe_n, 1'b0)
        @(posedge hclk);
        init_done <= 1'b1;
        clk_hold <= 1'b1;
        `WAITC(run_oe_n === 1'b1, 20)
        `CHK(run_oe_n, 1'b1)
        bus(OFS_STATUS, 1'b0, 32'h00000000, t);
        `CHK(t[10:8], 3'h1)
        peer_ready <= 1'b1;
        repeat (5000) @(negedge hclk);
        `CHK(force_dcm, 1'b0)
        `CHK(switching_en, 1'b0)
        // Release right after our own clock falls, so the first tick lands a fixed half period later
        `WAITC(share_clk_oe_n === 1'b1, 1100)
        `WAITC(share_clk_oe_n === 1'b0, 600)
        @(posedge hclk);
        clk_hold <= 1'b0;
        bottom_gate_req <= 1'b1;
        `WAITC(force_dcm === 1'b1, 4000)
        `CHK(n > 1995 && n < 3020, 1'b1)
        `WAITC(target_code !== 16'h0000, 12000)
        `CHK(pwm_mode, MODE_DCM)
        `CHK(switching_en, 1'b1)
        `CHK(target_code > 16'h0000 && target_code < 16'h0032, 1'b1)
        `CHK(bottom_gate_en, 1'b1)
        @(posedge hclk);
        reverse_current <= 1'b1;
        repeat (6) @(negedge hclk);
        `CHK(bottom_gate_en, 1'b0)
        @(posedge hclk);
        reverse_current <= 1'b0;
        steps = 1;
        last = target_code;
        n = 0;
        while (target_code !== 16'h0064 && n < 25000)
        begin
            @(negedge hclk);
            n++;
            if (target_code !== last)
                steps++;
            last = target_code;
        end
        `CHK(steps, 3)
        `CHK(n > 19980 && n < 20010, 1'b1)
        repeat (50) @(negedge hclk);
        `CHK(force_dcm, 1'b1)
        `CHK(servo_start, 1'b0)
        `CHK(gpio_oe_n, 1'b0)
        @(posedge hclk);
        vout_above_uv <= 1'b1;
        `WAITC(servo_start === 1'b1, 20)
        `CHK(pwm_mode, 2'h2)
        `CHK(force_dcm, 1'b0)
        `CHK(gpio_oe_n, 1'b1)
        // A dip shorter than the filter must not reach the line
        wr(OFS_PROPAGATE, 32'h00000003);
        // Filtered indication needs a full filter span to follow the rise first
        repeat (30) @(negedge hclk);
        `CHK(gpio_oe_n, 1'b1)
        @(posedge hclk);
        vout_above_uv <= 1'b0;
        repeat (10) @(posedge hclk);
        vout_above_uv <= 1'b1;
        steps = 0;
        repeat (40) @(negedge hclk) if (gpio_oe_n !== 1'b1) steps++;
        `CHK(steps, 0)
        @(posedge hclk);
        vout_above_uv <= 1'b0;
        `WAITC(gpio_oe_n === 1'b0, 60)
        `CHK(n > 17 && n < 40, 1'b1)
        @(posedge hclk);
        vout_above_uv <= 1'b1;
        peer_ready <= 1'b0;
        repeat (20) @(negedge hclk);
        `CHK(target_code, 16'h0000)
        `CHK(servo_start, 1'b0)
        wr(OFS_RISE, 32'h00000018);
        peer_ready <= 1'b1;
        `WAITC(force_dcm === 1'b1, 4000)
        `WAITC(target_code === 16'h0064, 100)
        `CHK(n < 60, 1'b1)
        wrap_up();
    end
endmodule : sss_sequencer_bench

// ### test/sss_sequencer_chk.sv
// Port checker of the start-up sequencer
`timescale 1ns/1ns
module sss_sequencer_chk
    import sss_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic init_done,
    input wire logic reverse_current,
    input wire logic run_oe_n,
    input wire logic gpio_oe_n,
    input wire logic [15:0] target_code,
    input wire logic force_dcm,
    input wire logic [1:0] pwm_mode,
    input wire logic servo_start,
    input wire logic bottom_gate_en
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic taken;
    assign taken = hsel && hready && htrans == HTRANS_NONSEQ && hreadyout;
    ////////////////////////////////////////////////////////////////
    AST_RUN_RELEASE: assert property ($rose(run_oe_n) |-> $past(init_done))
        else $error("run line released before init");
    AST_OKAY: assert property (hresp == 1'b0)
        else $error("bus response not okay");
    AST_READ_WAIT: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    AST_WRITE_NOWAIT: assert property (taken && hwrite |=> hreadyout)
        else $error("write wait state wrong");
    AST_DCM_RAMP: assert property (force_dcm |-> pwm_mode == MODE_DCM)
        else $error("mode not discontinuous while forced");
    AST_DCM_WHILE_STEP: assert property ($changed(target_code) && target_code != 16'h0000 |-> force_dcm)
        else $error("target stepped outside forced discontinuous mode");
    AST_MODE_AT_SERVO: assert property ($rose(servo_start) |-> $fell(force_dcm))
        else $error("mode change not with servo start");
    AST_REVERSE_OFF: assert property (pwm_mode == MODE_DCM && $past(reverse_current, 2) &&
        $past(reverse_current, 3) && $past(reverse_current, 4) |-> !bottom_gate_en)
        else $error("bottom gate on with reverse current");
    AST_RAMP_UP: assert property (force_dcm && $past(force_dcm) |-> target_code >= $past(target_code))
        else $error("target fell during ramp");
    COV_SERVO: cover property ($rose(servo_start));
    COV_RAMP: cover property ($rose(force_dcm));
    COV_GPIO: cover property ($fell(gpio_oe_n));
endmodule : sss_sequencer_chk

bind sss_sequencer sss_sequencer_chk u_chk (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout,
    .hresp, .init_done, .reverse_current, .run_oe_n, .gpio_oe_n, .target_code, .force_dcm, .pwm_mode,
    .servo_start, .bottom_gate_en);
